// ### verification/constant_output_port_path_tb.sv
`timescale 1ns/1ps
`default_nettype none
module constant_output_port_path_tb;
   logic              core_clk;
   logic              rst_n;
   logic              op_valid;
   logic              op_ready;
   ocp_pkg::ocp_cmd_t op_cmd;
   logic              sleep;
   logic [7:0]        out_value_bus;
   logic [7:0]        port_number_bus;
   logic              write_strobe;
   logic              k_write_strobe;
   logic              reg_wr_en;
   logic [3:0]        reg_wr_addr;
   logic [7:0]        reg_wr_data;
   logic [15:0]       cap_count;
   logic              overflow;
   logic              fifo_empty;
   logic [7:0]        prev_port;
   logic [7:0]        prev_val;
   logic [2:0]        kind;
   ocp_pkg::ocp_cmd_t mon_e;
   ocp_pkg::ocp_cmd_t exp_q[$];
   int                num_errors = 0;
   int                check_count = 0;
   int                exp_cap = 0;
   int                gap = 9;
   integer            seed = 32'hdea4;
   string             msg = "Build revision: ";

   ocp_port_path #(.BUILD_VALUE(8'h41)) i_ocp_port_path (.core_clk(core_clk), .rst_n(rst_n),
      .op_valid(op_valid), .op_ready(op_ready), .op_cmd(op_cmd), .sleep(sleep),
      .out_value_bus(out_value_bus), .port_number_bus(port_number_bus), .write_strobe(write_strobe),
      .k_write_strobe(k_write_strobe), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data));
   ocp_tx_fifo_model i_ocp_tx_fifo_model (.core_clk(core_clk), .rst_n(rst_n),
      .out_value_bus(out_value_bus), .port_number_bus(port_number_bus), .write_strobe(write_strobe),
      .k_write_strobe(k_write_strobe), .half_full(sleep), .cap_count(cap_count), .overflow(overflow),
      .empty(fifo_empty));

   task automatic fail(input string m);
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
   endtask

   task automatic wrap_up();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Valid stays high between operations so it is never driven twice in one step
   task automatic send(input ocp_pkg::ocp_op_t op, input logic [3:0] dst, input logic [7:0] val,
                       input logic [7:0] port);
      ocp_pkg::ocp_cmd_t e;
      op_valid = 1'b1;
      op_cmd = '{op, dst, val, port};
      while (op_ready !== 1'b1) @(posedge core_clk) #1;
      @(posedge core_clk) #1;
      e = op_cmd;
      if (op == ocp_pkg::OCP_OP_OUT_CONST) e.port = {4'h0, port[3:0]};
      if (op == ocp_pkg::OCP_OP_BUILD) e.value = 8'h41;
      if (op != ocp_pkg::OCP_OP_NOP) exp_q.push_back(e);
      if (op < ocp_pkg::OCP_OP_BUILD && e.port[3]) exp_cap++;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Strobes are one cycle wide: sampled mid-cycle, away from the launching edge
   always @(negedge core_clk) begin
      if (rst_n && (write_strobe | k_write_strobe | reg_wr_en) !== 1'b0) begin
         check_count++;
         if (exp_q.size() == 0) fail("pulse without operation");
         else begin
            mon_e = exp_q.pop_front();
            kind = (mon_e.op == ocp_pkg::OCP_OP_OUT_REG) ? 3'b100 :
                   (mon_e.op == ocp_pkg::OCP_OP_OUT_CONST) ? 3'b010 : 3'b001;
            if ({write_strobe, k_write_strobe, reg_wr_en} !== kind) fail("wrong strobe");
            if (mon_e.op == ocp_pkg::OCP_OP_BUILD && {reg_wr_addr, reg_wr_data} !== {mon_e.dst, mon_e.value})
               fail("build value");
            if (mon_e.op != ocp_pkg::OCP_OP_BUILD && {out_value_bus, port_number_bus} !== {mon_e.value, mon_e.port})
               fail("port data");
            if ({prev_val, prev_port} !== {out_value_bus, port_number_bus}) fail("bus not held");
            if (gap < 2) fail("pulses too close");
         end
         gap = 0;
      end
      prev_port = port_number_bus;
      prev_val = out_value_bus;
      gap++;
   end

   initial begin
      rst_n = 1'b0;
      op_valid = 1'b0;
      op_cmd = '0;
      repeat (8) @(posedge core_clk);
      #1 rst_n = 1'b1;
      while (fifo_empty !== 1'b1) @(posedge core_clk) #1;
      // Upper port bits set on purpose: constant writes must drop them
      for (int i = 0; i < msg.len(); i++) send(ocp_pkg::OCP_OP_OUT_CONST, 4'h0, msg[i], 8'hf8);
      send(ocp_pkg::OCP_OP_BUILD, 4'h5, 8'h00, 8'h08);
      send(ocp_pkg::OCP_OP_OUT_REG, 4'h0, 8'h41, 8'h08);
      send(ocp_pkg::OCP_OP_OUT_CONST, 4'h0, 8'h0d, 8'h08);
      repeat (60) send(ocp_pkg::ocp_op_t'(2'($random(seed))), 4'($random(seed)), 8'($random(seed)),
                       8'($random(seed)));
      op_valid = 1'b0;
      for (int n = 0; n < 400 && exp_q.size() > 0; n++) @(posedge core_clk);
      repeat (4) @(posedge core_clk);
      check_count++;
      if (cap_count !== 16'(exp_cap) || overflow !== 1'b0) fail("capture count");
      if (exp_q.size() != 0) fail("missing pulses");
      wrap_up();
   end

   initial begin
      #100000;
      num_errors++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      wrap_up();
   end
endmodule // constant_output_port_path_tb
`default_nettype wire

// ### verification/ocp_tx_fifo_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocp_tx_fifo_model #(
   parameter int DRAIN = 6
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] out_value_bus,
   input  wire logic [7:0] port_number_bus,
   input  wire logic       write_strobe,
   input  wire logic       k_write_strobe,
   output logic            half_full,
   output logic [15:0]     cap_count,
   output logic            overflow,
   output logic            empty
);
   logic [4:0] fill_r;
   logic [7:0] div_r;
   logic       push;
   logic       pop;
   // Bit 3 alone decoded: one hybrid port at 08 fed by both pulses
   assign push = (write_strobe | k_write_strobe) & port_number_bus[3];
   // Drains slower than one byte per two cycles, so sleep must throttle
   assign pop = (div_r == 8'(DRAIN)) && (fill_r != 5'h00);
   assign half_full = fill_r >= 5'h08;
   // Lets the issuer confirm free space before a burst
   assign empty = (fill_r == 5'h00);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fill_r <= 5'h00;
         div_r <= 8'h00;
         cap_count <= 16'h0000;
         overflow <= 1'b0;
      end else begin
         div_r <= (div_r == 8'(DRAIN)) ? 8'h00 : div_r + 8'h01;
         fill_r <= fill_r + 5'(push) - 5'(pop);
         if (push) begin
            cap_count <= cap_count + 16'h0001;
            if (fill_r == 5'h10 && !pop) overflow <= 1'b1;
         end
      end
   end
endmodule // ocp_tx_fifo_model
`default_nettype wire

// ### verilog/ocp_buf2.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocp_map.svh"

module ocp_buf2 (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              in_valid,
   output logic                   in_ready,
   input  wire ocp_pkg::ocp_cmd_t in_data,
   output logic                   out_valid,
   input  wire logic              out_ready,
   output ocp_pkg::ocp_cmd_t      out_data
);

   ocp_pkg::ocp_buf_st_t st_r;
   ocp_pkg::ocp_buf_st_t st_nxt;
   logic                 push;
   logic                 pop;

   assign in_ready  = (st_r.cnt != `OCP_BUF_DEPTH);
   assign out_valid = (st_r.cnt != `OCP_RST_CNT);
   assign out_data  = st_r.mem[st_r.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wp] = in_data;
         st_nxt.wp           = ~st_r.wp;
      end
      if (pop) begin
         st_nxt.rp = ~st_r.rp;
      end
      case ({push, pop})
         2'h2:    st_nxt.cnt = st_r.cnt + 2'h1;
         2'h1:    st_nxt.cnt = st_r.cnt - 2'h1;
         default: st_nxt.cnt = st_r.cnt;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule // ocp_buf2

`default_nettype wire

// ### verilog/ocp_map.svh
`ifndef OCP_MAP_SVH
`define OCP_MAP_SVH

// Reset values
`define OCP_RST_BYTE      8'h00
`define OCP_RST_NIBBLE    4'h0
`define OCP_RST_PTR       1'b0
`define OCP_RST_CNT       2'h0

// Fixed value loaded by the build-code operation
`define OCP_BUILD_DEFAULT 8'h41

// Constant-output port number field
`define OCP_KPORT_LSB     0
`define OCP_KPORT_MSB     3
`define OCP_KPORT_UPPER   4'h0

// Timing
`define OCP_INSTR_CYCLES  2
`define OCP_BUF_DEPTH     2'h2

`endif

// ### verilog/ocp_pkg.sv
package ocp_pkg;

   typedef enum logic [1:0] {
      OCP_OP_OUT_REG   = 2'h0,
      OCP_OP_OUT_CONST = 2'h1,
      OCP_OP_BUILD     = 2'h2,
      OCP_OP_NOP       = 2'h3
   } ocp_op_t;

   typedef struct packed {
      ocp_op_t    op;
      logic [3:0] dst;
      logic [7:0] value;
      logic [7:0] port;
   } ocp_cmd_t;

   typedef enum logic [2:0] {
      OCP_IDLE   = 3'h1,
      OCP_SETUP  = 3'h2,
      OCP_STROBE = 3'h4
   } ocp_fsm_t;

   typedef struct packed {
      ocp_cmd_t   [1:0] mem;
      logic             wp;
      logic             rp;
      logic [1:0]       cnt;
   } ocp_buf_st_t;

   typedef struct packed {
      ocp_fsm_t   fsm;
      ocp_cmd_t   cmd;
      logic [7:0] out_value;
      logic [7:0] port;
   } ocp_core_st_t;

endpackage

// ### verilog/ocp_port_path.sv
// Overview of operation
// - A constant-output operation drives its own 8-bit immediate byte onto the output value bus.
// - A constant-output operation carries a 4-bit port number that appears on the low four port number bits.
// - A constant-output operation writes no general register and touches neither flag.
// - Every operation, constant-output included, lasts two clock cycles, so constant writes can follow every two cycles.
// - The build-code operation loads the named register with a fixed build-time byte, 41 hex by default.
// - Up to sixteen constant ports exist; the constant pulse qualifies port bits 3..0 and bits 7..4 mean nothing.
// - The variable-output pulse rises only for a register-sourced output, though the buses change at other times.
// - The port number is held so outside logic has two cycles to decode it before the write pulse edge.
`timescale 1ns/1ps
`default_nettype none
`include "ocp_map.svh"

module ocp_port_path #(
   parameter logic [7:0] BUILD_VALUE = `OCP_BUILD_DEFAULT
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              op_valid,
   output logic                   op_ready,
   input  wire ocp_pkg::ocp_cmd_t op_cmd,
   input  wire logic              sleep,
   output logic [7:0]             out_value_bus,
   output logic [7:0]             port_number_bus,
   output logic                   write_strobe,
   output logic                   k_write_strobe,
   output logic                   reg_wr_en,
   output logic [3:0]             reg_wr_addr,
   output logic [7:0]             reg_wr_data
);

   ocp_pkg::ocp_core_st_t st_r;
   ocp_pkg::ocp_core_st_t st_nxt;
   ocp_pkg::ocp_cmd_t     head;
   logic                  head_valid;
   logic                  take;

   // Two entries let the issuer run ahead while sleep holds the port path
   ocp_buf2 i_ocp_buf2 (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_valid  (op_valid),
      .in_ready  (op_ready),
      .in_data   (op_cmd),
      .out_valid (head_valid),
      .out_ready (take),
      .out_data  (head)
   );

   always_comb begin
      st_nxt = st_r;
      take   = 1'b0;
      case (st_r.fsm)
         ocp_pkg::OCP_IDLE: begin
            // Sleep only blocks a new start; an operation in flight finishes
            take = head_valid && !sleep;
         end
         ocp_pkg::OCP_SETUP: begin
            st_nxt.fsm = ocp_pkg::OCP_STROBE;
         end
         ocp_pkg::OCP_STROBE: begin
            take = head_valid && !sleep;
            if (!take) begin
               st_nxt.fsm = ocp_pkg::OCP_IDLE;
            end
         end
         default: begin
            st_nxt.fsm = ocp_pkg::OCP_IDLE;
         end
      endcase
      if (take) begin
         st_nxt.fsm = ocp_pkg::OCP_SETUP;
         st_nxt.cmd = head;
         case (head.op)
            ocp_pkg::OCP_OP_OUT_CONST: begin
               st_nxt.out_value = head.value;
               // Upper bits forced low; they carry no meaning here
               st_nxt.port = {`OCP_KPORT_UPPER, head.port[`OCP_KPORT_MSB:`OCP_KPORT_LSB]};
            end
            ocp_pkg::OCP_OP_BUILD: begin
               st_nxt.out_value = BUILD_VALUE;
               st_nxt.port      = head.port;
            end
            default: begin
               st_nxt.out_value = head.value;
               st_nxt.port      = head.port;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r.fsm       <= ocp_pkg::OCP_IDLE;
         st_r.cmd       <= '0;
         st_r.out_value <= `OCP_RST_BYTE;
         st_r.port      <= `OCP_RST_BYTE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign out_value_bus   = st_r.out_value;
   // Held through setup and strobe cycles: two cycles of decode time
   assign port_number_bus = st_r.port;
   assign write_strobe    = (st_r.fsm == ocp_pkg::OCP_STROBE)
                            && (st_r.cmd.op == ocp_pkg::OCP_OP_OUT_REG);
   assign k_write_strobe  = (st_r.fsm == ocp_pkg::OCP_STROBE)
                            && (st_r.cmd.op == ocp_pkg::OCP_OP_OUT_CONST);
   // Only build-code writes a register; output operations leave them alone
   assign reg_wr_en       = (st_r.fsm == ocp_pkg::OCP_STROBE)
                            && (st_r.cmd.op == ocp_pkg::OCP_OP_BUILD);
   assign reg_wr_addr     = st_r.cmd.dst;
   assign reg_wr_data     = st_r.out_value;

   logic take_const;
   logic take_reg;
   logic take_build;
   logic any_pulse;

   assign take_const = take && (head.op == ocp_pkg::OCP_OP_OUT_CONST);
   assign take_reg   = take && (head.op == ocp_pkg::OCP_OP_OUT_REG);
   assign take_build = take && (head.op == ocp_pkg::OCP_OP_BUILD);
   assign any_pulse  = write_strobe || k_write_strobe || reg_wr_en;

   a_const_value: assert property (@(posedge core_clk) disable iff (!rst_n)
      take_const |-> ##2 (k_write_strobe && out_value_bus == $past(head.value, 2)))
      else $error("constant byte not presented with its pulse");

   a_const_port: assert property (@(posedge core_clk) disable iff (!rst_n)
      take_const |-> ##2 (port_number_bus[3:0] == $past(head.port[3:0], 2)))
      else $error("constant port number wrong");

   a_kport_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
      k_write_strobe |-> (port_number_bus[7:4] == 4'h0 && !write_strobe))
      else $error("constant write has stray upper port bits");

   a_no_reg_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      take_const |-> ##1 !reg_wr_en [*2])
      else $error("constant output wrote a register");

   a_two_cycle: assert property (@(posedge core_clk) disable iff (!rst_n)
      (take_const || take_reg || take_build) |=> (!any_pulse ##1 any_pulse))
      else $error("operation did not take two cycles");

   a_pulse_spacing: assert property (@(posedge core_clk) disable iff (!rst_n)
      any_pulse |=> !any_pulse)
      else $error("pulses closer than two cycles");

   a_build_value: assert property (@(posedge core_clk) disable iff (!rst_n)
      take_build |-> ##2 (reg_wr_en && reg_wr_data == BUILD_VALUE
                          && reg_wr_addr == $past(head.dst, 2)))
      else $error("build-code loaded wrong value or register");

   a_var_only: assert property (@(posedge core_clk) disable iff (!rst_n)
      write_strobe |-> $past(take_reg, 2))
      else $error("variable pulse without register output");

   a_port_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
      any_pulse |-> ($stable(port_number_bus) && $stable(out_value_bus)))
      else $error("port number moved inside decode window");

   a_sleep_block: assert property (@(posedge core_clk) disable iff (!rst_n)
      sleep |-> !take)
      else $error("operation started while asleep");

   // Sleep must pause starts, never strand one already in setup
   a_sleep_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r.fsm == ocp_pkg::OCP_IDLE && sleep) |=> (st_r.fsm == ocp_pkg::OCP_IDLE))
      else $error("idle port path left idle while asleep");

   a_wake_start: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r.fsm == ocp_pkg::OCP_IDLE && head_valid && !sleep) |=> (st_r.fsm == ocp_pkg::OCP_SETUP))
      else $error("waiting operation not started after sleep released");

   a_sleep_finish: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r.fsm == ocp_pkg::OCP_SETUP) |=> (st_r.fsm == ocp_pkg::OCP_STROBE))
      else $error("operation in setup did not reach its pulse");

   // Back-to-back issue is what gives the two-cycle port rate
   a_back_to_back: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r.fsm == ocp_pkg::OCP_STROBE && head_valid && !sleep) |=> (st_r.fsm == ocp_pkg::OCP_SETUP))
      else $error("queued operation not issued right after pulse");

   a_fsm_onehot: assert property (@(posedge core_clk) disable iff (!rst_n)
      $onehot(st_r.fsm))
      else $error("port path state not one-hot");

   // Buses must settle a full cycle before any pulse is sampled
   a_decode_window: assert property (@(posedge core_clk) disable iff (!rst_n)
      any_pulse |-> ($past(st_r.fsm) == ocp_pkg::OCP_SETUP))
      else $error("pulse without a setup cycle before it");

   a_nop_silent: assert property (@(posedge core_clk) disable iff (!rst_n)
      (take && head.op == ocp_pkg::OCP_OP_NOP) |-> ##2 !any_pulse)
      else $error("no-op operation raised a pulse");

   a_reg_output: assert property (@(posedge core_clk) disable iff (!rst_n)
      take_reg |-> ##2 (write_strobe && out_value_bus == $past(head.value, 2)
                        && port_number_bus == $past(head.port, 2)))
      else $error("register output not presented with its pulse");

   c_back_to_back: cover property (@(posedge core_clk) disable iff (!rst_n)
      k_write_strobe ##2 k_write_strobe);
   c_sleep_stall: cover property (@(posedge core_clk) disable iff (!rst_n)
      (head_valid && sleep) [*3] ##1 !sleep);
   c_build: cover property (@(posedge core_clk) disable iff (!rst_n)
      reg_wr_en ##2 write_strobe);
   c_buf_full: cover property (@(posedge core_clk) disable iff (!rst_n)
      op_valid && !op_ready);
   c_hybrid: cover property (@(posedge core_clk) disable iff (!rst_n)
      write_strobe ##2 k_write_strobe);

endmodule // ocp_port_path

`default_nettype wire
